// ===== src/spi_pin_interface.v
`timescale 1ns/1ns
`include "spi_pin_regs.vh"
// Functional notes
// - miso input as master, output when selected
// - unselected slave releases miso
// - master drives mosi, slave samples it
// - mosi set half period before capture edge
// - master drives clock, slave receives it
// - master mode: select arbitrates masters
// - slave active only while select low
// - each pin usable as directed gpio
// - pins default to serial function
module spi_pin_interface (
    input wire clock_in,
    input wire srst_in,
    input wire master_mode_in,
    input wire [7:0] half_div_in,
    input wire start_in,
    input wire [7:0] tx_data_in,
    output wire busy_out,
    output reg [7:0] rx_data_out,
    output reg rx_valid_out,
    output reg mode_fault_out,
    input wire [3:0] func_sel_in,
    input wire [3:0] gpio_dir_in,
    input wire [3:0] gpio_out_in,
    output wire [3:0] gpio_in_out,
    input wire [3:0] pin_in,
    output reg [3:0] pin_out,
    output reg [3:0] pin_oe_out
);
    localparam ST_IDLE = 2'h0;
    localparam ST_LEAD = 2'h1;
    localparam ST_TRAIL = 2'h2;

    wire [3:0] pin_sync_w;
    reg [1:0] state_ff;
    reg [7:0] cnt_ff;
    reg [3:0] bit_ff;
    reg [7:0] shift_ff;
    reg clk_ff;
    reg mosi_ff;
    reg miso_ff;
    reg sclk_d_ff;
    reg [3:0] func_ff;
    reg [3:0] dir_ff;
    reg [3:0] gout_ff;
    reg [3:0] slv_bits_ff;

    // ****************************************
    // input synchronisers
    // ****************************************
    pin_sync u_sync (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .async_in(pin_in),
        .sync_out(pin_sync_w)
    );

    assign gpio_in_out = pin_sync_w;

    function is_gpio;
        input [3:0] sel;
        input [1:0] idx;
        begin
            is_gpio = sel[idx];
        end
    endfunction

    function [7:0] shift_in;
        input [7:0] cur;
        input din;
        begin
            shift_in = {cur[6:0], din};
        end
    endfunction

    function is_last;
        input [3:0] cnt;
        begin
            is_last = (cnt == `FRAME_BITS - 4'h1);
        end
    endfunction

    wire serial_clk = !is_gpio(func_ff, `PIN_CLOCK);
    wire select_low = !pin_sync_w[`PIN_SELECT] && !is_gpio(func_ff, `PIN_SELECT);
    wire selected = !master_mode_in && select_low;
    wire sclk_s = pin_sync_w[`PIN_CLOCK];
    wire sclk_rise = sclk_s && !sclk_d_ff && serial_clk;
    wire sclk_fall = !sclk_s && sclk_d_ff && serial_clk;
    wire [7:0] half = (half_div_in < `HALF_MIN) ? `HALF_MIN : half_div_in;

    assign busy_out = (state_ff != ST_IDLE);

    // ****************************************
    // pin configuration registers
    // ****************************************
    always @(posedge clock_in) begin
        if (srst_in) begin
            func_ff <= `FUNC_SEL_RESET;
            dir_ff <= `GPIO_DIR_RESET;
            gout_ff <= `GPIO_OUT_RESET;
        end else begin
            func_ff <= func_sel_in;
            dir_ff <= gpio_dir_in;
            gout_ff <= gpio_out_in;
        end
    end

    // ****************************************
    // master and slave engine
    // ****************************************
    always @(posedge clock_in) begin
        if (srst_in) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 8'h00;
            bit_ff <= 4'h0;
            shift_ff <= 8'h00;
            clk_ff <= 1'b0;
            mosi_ff <= 1'b0;
            miso_ff <= 1'b0;
            sclk_d_ff <= 1'b0;
            slv_bits_ff <= 4'h0;
            rx_data_out <= 8'h00;
            rx_valid_out <= 1'b0;
            mode_fault_out <= 1'b0;
        end else begin
            rx_valid_out <= 1'b0;
            sclk_d_ff <= sclk_s;
            if (master_mode_in && select_low) begin
                // another master holds the bus
                mode_fault_out <= 1'b1;
                state_ff <= ST_IDLE;
                clk_ff <= 1'b0;
            end else if (master_mode_in) begin
                mode_fault_out <= 1'b0;
                case (state_ff)
                    ST_IDLE: begin
                        clk_ff <= 1'b0;
                        if (start_in) begin
                            shift_ff <= tx_data_in;
                            mosi_ff <= tx_data_in[7];
                            bit_ff <= 4'h0;
                            cnt_ff <= half;
                            state_ff <= ST_LEAD;
                        end
                    end
                    ST_LEAD: begin
                        if (cnt_ff == 8'h01) begin
                            clk_ff <= 1'b1;
                            shift_ff <= shift_in(shift_ff, pin_sync_w[`PIN_MISO]);
                            cnt_ff <= half;
                            state_ff <= ST_TRAIL;
                        end else begin
                            cnt_ff <= cnt_ff - 8'h01;
                        end
                    end
                    ST_TRAIL: begin
                        if (cnt_ff == 8'h01) begin
                            clk_ff <= 1'b0;
                            cnt_ff <= half;
                            if (is_last(bit_ff)) begin
                                rx_data_out <= shift_ff;
                                rx_valid_out <= 1'b1;
                                state_ff <= ST_IDLE;
                            end else begin
                                bit_ff <= bit_ff + 4'h1;
                                mosi_ff <= shift_ff[7];
                                state_ff <= ST_LEAD;
                            end
                        end else begin
                            cnt_ff <= cnt_ff - 8'h01;
                        end
                    end
                    default: state_ff <= ST_IDLE;
                endcase
            end else begin
                // slave: capture on rise, shift out on fall
                mode_fault_out <= 1'b0;
                state_ff <= ST_IDLE;
                clk_ff <= 1'b0;
                if (!selected) begin
                    slv_bits_ff <= 4'h0;
                    shift_ff <= tx_data_in;
                    miso_ff <= tx_data_in[7];
                end else if (sclk_rise) begin
                    shift_ff <= shift_in(shift_ff, pin_sync_w[`PIN_MOSI]);
                    if (is_last(slv_bits_ff)) begin
                        rx_data_out <= shift_in(shift_ff, pin_sync_w[`PIN_MOSI]);
                        rx_valid_out <= 1'b1;
                        slv_bits_ff <= 4'h0;
                    end else begin
                        slv_bits_ff <= slv_bits_ff + 4'h1;
                    end
                end else if (sclk_fall) begin
                    miso_ff <= (slv_bits_ff == 4'h0) ? tx_data_in[7] : shift_ff[7];
                    if (slv_bits_ff == 4'h0) begin
                        shift_ff <= tx_data_in;
                    end
                end
            end
        end
    end

    // ****************************************
    // pin muxing
    // ****************************************
    always @* begin
        pin_out = gout_ff;
        pin_oe_out = dir_ff;
        if (!func_ff[`PIN_CLOCK]) begin
            pin_out[`PIN_CLOCK] = clk_ff;
            pin_oe_out[`PIN_CLOCK] = master_mode_in;
        end
        if (!func_ff[`PIN_MOSI]) begin
            pin_out[`PIN_MOSI] = mosi_ff;
            pin_oe_out[`PIN_MOSI] = master_mode_in;
        end
        if (!func_ff[`PIN_MISO]) begin
            pin_out[`PIN_MISO] = miso_ff;
            pin_oe_out[`PIN_MISO] = selected;
        end
        if (!func_ff[`PIN_SELECT]) begin
            pin_out[`PIN_SELECT] = 1'b0;
            pin_oe_out[`PIN_SELECT] = 1'b0;
        end
    end
endmodule

// ===== src/spi_pin_regs.vh
`ifndef SPI_PIN_REGS_VH
`define SPI_PIN_REGS_VH
// ****************************************
// pin indices within the shared group
// ****************************************
`define PIN_CLOCK 2'h0
`define PIN_MOSI 2'h1
`define PIN_MISO 2'h2
`define PIN_SELECT 2'h3
// ****************************************
// reset values
// ****************************************
`define FUNC_SEL_RESET 4'h0
`define GPIO_DIR_RESET 4'h0
`define GPIO_OUT_RESET 4'h0
`define DIV_RESET 8'h04
`define SYNC_RESET 4'h8
// ****************************************
// frame and timing
// ****************************************
`define FRAME_BITS 4'h8
`define HALF_MIN 8'h01
`endif

// ===== src/pin_sync.v
`timescale 1ns/1ns
`include "spi_pin_regs.vh"
// ****************************************
// two-stage synchroniser per pin
// ****************************************
module pin_sync (
    input wire clock_in,
    input wire srst_in,
    input wire [3:0] async_in,
    output reg [3:0] sync_out
);
    reg [3:0] meta_ff;
    always @(posedge clock_in) begin
        if (srst_in) begin
            meta_ff <= `SYNC_RESET;
            sync_out <= `SYNC_RESET;
        end else begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

// ===== tb/spi_pin_sva.sv
`timescale 1ns/1ns
// ****
// pin role checks
// ****
module spi_pin_sva (
    input wire clock_in,
    input wire srst_in,
    input wire master_mode_in,
    input wire [7:0] half_div_in,
    input wire busy_out,
    input wire rx_valid_out,
    input wire mode_fault_out,
    input wire [3:0] func_sel_in,
    input wire [3:0] gpio_dir_in,
    input wire [3:0] pin_in,
    input wire [3:0] pin_out,
    input wire [3:0] pin_oe_out
);
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (srst_in);
    property p_miso_in; (!func_sel_in[2] && master_mode_in)[*2] |-> !pin_oe_out[2]; endproperty
    a_miso_in: assert property (p_miso_in) else $error("miso driven");
    property p_miso_off;
        (!func_sel_in[2] && !master_mode_in && pin_in[3])[*4] |-> !pin_oe_out[2];
    endproperty
    a_miso_off: assert property (p_miso_off) else $error("miso not released");
    property p_mosi_dir;
        (!func_sel_in[1] && $stable(master_mode_in))[*2] |-> pin_oe_out[1] == master_mode_in;
    endproperty
    a_mosi_dir: assert property (p_mosi_dir) else $error("mosi direction");
    property p_clk_dir;
        (!func_sel_in[0] && $stable(master_mode_in))[*2] |-> pin_oe_out[0] == master_mode_in;
    endproperty
    a_clk_dir: assert property (p_clk_dir) else $error("clock direction");
    property p_setup;
        $rose(pin_out[0]) && busy_out && half_div_in > 8'h03
            |-> $stable(pin_out[1]) && $past(pin_out[1], 3) == pin_out[1];
    endproperty
    a_setup: assert property (p_setup) else $error("mosi setup");
    property p_arbit;
        (master_mode_in && !func_sel_in[3] && !pin_in[3])[*5] |-> mode_fault_out && !busy_out;
    endproperty
    a_arbit: assert property (p_arbit) else $error("no arbitration");
    property p_gate; (!master_mode_in && pin_in[3])[*6] |-> !rx_valid_out; endproperty
    a_gate: assert property (p_gate) else $error("slave unselected");
    property p_gpio;
        $stable(func_sel_in) && $stable(gpio_dir_in) && func_sel_in == 4'hf
            |-> pin_oe_out == gpio_dir_in;
    endproperty
    a_gpio: assert property (p_gpio) else $error("gpio direction");
    property p_reset; disable iff (1'b0) srst_in && master_mode_in |=> pin_oe_out == 4'h3; endproperty
    a_reset: assert property (p_reset) else $error("reset function");
    c_master: cover property (rx_valid_out && master_mode_in);
    c_slave: cover property (rx_valid_out && !master_mode_in);
    c_fault: cover property (mode_fault_out);
endmodule
bind spi_pin_interface spi_pin_sva u_sva (.*);

// ===== tb/spi_slave_model.sv
`timescale 1ns/1ns
// ****
// far-side slave
// ****
module spi_slave_model (
    input wire sclk_in,
    input wire select_n_in,
    input wire mosi_in,
    input wire [7:0] reply_in,
    output wire miso_out,
    output wire miso_oe_out,
    output reg [7:0] got_out
);
    reg [7:0] sh_ff;
    assign miso_out = sh_ff[7];
    assign miso_oe_out = !select_n_in;
    always @(negedge select_n_in) sh_ff <= reply_in;
    always @(posedge sclk_in) if (!select_n_in) got_out <= {got_out[6:0], mosi_in};
    always @(negedge sclk_in) if (!select_n_in) sh_ff <= sh_ff << 1;
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ns
// ****
// bench
// ****
module tb_top;
    reg clock_in = 0;
    reg srst_in = 1;
    reg master_mode_in = 1;
    reg start_in = 0;
    reg [7:0] tx_data_in = 8'h00;
    reg [3:0] func_sel_in = 4'h0;
    reg [3:0] gpio_dir_in = 4'h0;
    reg [3:0] gpio_out_in = 4'h1;
    reg bclk = 0, bmosi = 0, bsel = 1, ssel_n = 1, tog = 0;
    reg [7:0] rep = 8'h00, last_rx = 8'h00;
    integer hits = 0, n_fail = 0, n_tests = 0;
    wire busy_out, rx_valid_out, mode_fault_out, s_miso, s_oe;
    wire [7:0] rx_data_out, got;
    wire [3:0] gpio_in_out, pin_out, pin_oe_out;
    wire [3:0] pad = {pin_oe_out[3] ? pin_out[3] : bsel,
        pin_oe_out[2] ? pin_out[2] : (s_oe ? s_miso : tog),
        pin_oe_out[1] ? pin_out[1] : (bsel ? tog : bmosi), pin_oe_out[0] ? pin_out[0] : bclk};
    spi_pin_interface dut (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .master_mode_in(master_mode_in),
        .half_div_in(8'h04),
        .start_in(start_in),
        .tx_data_in(tx_data_in),
        .busy_out(busy_out),
        .rx_data_out(rx_data_out),
        .rx_valid_out(rx_valid_out),
        .mode_fault_out(mode_fault_out),
        .func_sel_in(func_sel_in),
        .gpio_dir_in(gpio_dir_in),
        .gpio_out_in(gpio_out_in),
        .gpio_in_out(gpio_in_out),
        .pin_in(pad),
        .pin_out(pin_out),
        .pin_oe_out(pin_oe_out)
    );
    spi_slave_model partner (.sclk_in(pad[0]), .select_n_in(ssel_n), .mosi_in(pad[1]),
        .reply_in(rep), .miso_out(s_miso), .miso_oe_out(s_oe), .got_out(got));
    always #25 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        tog <= ~tog;
        if (rx_valid_out) begin
            last_rx <= rx_data_out;
            hits <= hits + 1;
        end
    end
    task chk(input [7:0] seen, input [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task m_xfer(input [7:0] t, input [7:0] r);
        integer n;
        n = hits;
        tx_data_in = t;
        rep = r;
        ssel_n = 0;
        start_in = 1;
        @(negedge clock_in) start_in = 0;
        repeat (200) if (hits == n) @(negedge clock_in);
        chk(last_rx, r);
        chk(got, t);
        ssel_n = 1;
        @(negedge clock_in);
    endtask
    task s_xfer(input [7:0] b, input [7:0] t);
        integer i;
        reg [7:0] seen;
        master_mode_in = 0;
        tx_data_in = t;
        repeat (5) @(negedge clock_in);
        chk({4'h0, pin_oe_out}, 8'h00);
        bsel = 0;
        for (i = 7; i >= 0; i--) begin
            bmosi = b[i];
            repeat (4) @(negedge clock_in);
            seen[i] = pad[2];
            bclk = 1;
            repeat (4) @(negedge clock_in);
            bclk = 0;
        end
        bsel = 1;
        chk(last_rx, b);
        chk(seen, t);
    endtask
    task stop_test;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clock_in);
        srst_in = 0;
        chk({4'h0, pin_oe_out}, 8'h03);
        repeat (2) @(negedge clock_in);
        chk({7'h00, mode_fault_out}, 8'h00);
        $display("reset test done");
        m_xfer(8'ha5, 8'h3c);
        m_xfer(8'h5a, 8'hc3);
        $display("master test done");
        start_in = 1;
        @(negedge clock_in) start_in = 0;
        repeat (20) @(negedge clock_in);
        bsel = 0;
        repeat (5) @(negedge clock_in);
        chk({busy_out, mode_fault_out}, 8'h01);
        bsel = 1;
        $display("fault test done");
        func_sel_in = 4'hf;
        gpio_dir_in = 4'h5;
        gpio_out_in = 4'h4;
        bmosi = 1;
        bsel = 0;
        repeat (4) @(negedge clock_in);
        chk({pin_oe_out, pin_out & 4'h5}, 8'h54);
        chk({4'h0, gpio_in_out & 4'ha}, 8'h02);
        func_sel_in = 4'h0;
        bsel = 1;
        $display("gpio test done");
        s_xfer(8'h96, 8'h6b);
        $display("slave test done");
        stop_test;
    end
    // watchdog, some eight times the expected run
    initial begin
        #100000;
        n_fail++;
        stop_test;
    end
endmodule
